// file: logic/fscb_card_port.sv
// Card-side bus port for two or four PC card sockets.
//
// Overview of operation
// - No input-acknowledge pin; I/O reads end on internal timing alone.
// - Mode zero offers two sockets, mode one offers four.
// - Mode one shares data, address, select, enable and I/O strobes.
// - In mode one socket B bus pins carry per-socket enables instead.
// - Insert and hold indicator outputs act only in mode one.
// - Shared data bus is sixteen bits, bidirectional, also serving IDE.
// - Address is 26 bits; memory 64 MB, I/O 64 KB.
// - IDE accesses put the register address on address bits two to zero.
// - I/O read strobe goes low to fetch data; select low with it.
// - I/O write strobe goes low to deliver data; select low with it.
// - Attribute select stays high for common memory accesses.
// - Select low means attribute memory or I/O space only.
// - Output enable goes low to read memory cards.
// - Direction high through reads, low through writes, both bytes.
// - Direction starts low after power-up.
// - Direction steers card transceivers only, never IDE ones.
// - Enabled socket drives even-byte and odd-byte chip enables low for wide accesses, only one of them for byte accesses.
// - Every socket has an identical signal set.
`timescale 1ns/1ns
`default_nettype none
module fscb_card_port
  import fscb_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  fourSocketMode,
  input  wire logic                  reqValid,
  output var  logic                  reqReady,
  input  wire logic [1:0]            reqCmd,
  input  wire logic                  reqAttr,
  input  wire logic                  reqIde,
  input  wire logic                  reqWide,
  input  wire logic [SOCK_W-1:0]     reqSocket,
  input  wire logic [ADDR_W-1:0]     reqAddr,
  input  wire logic [DATA_W-1:0]     reqWrData,
  input  wire logic [NUM_SOCK-1:0]   socketEnable,
  input  wire logic [NUM_SOCK-1:0]   socketInserted,
  input  wire logic                  holdRequest,
  output var  logic                  rspValid,
  output var  logic [DATA_W-1:0]     rspRdData,
  input  wire logic [DATA_W-1:0]     shared_card_data_in,
  output var  logic [DATA_W-1:0]     shared_card_data_out,
  output var  logic                  shared_card_data_oe,
  output var  logic [ADDR_W-1:0]     shared_card_addr,
  output var  logic                  attrSelect_n,
  output var  logic                  outputEnable_n,
  output var  logic                  writeEnable_n,
  output var  logic                  ioRead_n,
  output var  logic                  ioWrite_n,
  output var  logic [2*NUM_SOCK-1:0] chipEnable_n,
  output var  logic                  ideCycle,
  output var  logic                  xcvr_direction,
  output var  logic [NUM_SOCK-1:0]   socket_insert_n,
  output var  logic                  hold_indicator_n
);
  logic                  syncRst_n;
  fscb_state_t           state;
  fscb_state_t           next_state;
  logic [3:0]            count;
  logic [3:0]            next_count;
  fscb_cmd_t             cmd;
  fscb_cmd_t             next_cmd;
  logic                  next_reqReady;
  logic                  next_rspValid;
  logic [DATA_W-1:0]     next_rspRdData;
  logic [DATA_W-1:0]     next_shared_card_data_out;
  logic                  next_shared_card_data_oe;
  logic [ADDR_W-1:0]     next_shared_card_addr;
  logic                  next_attrSelect_n;
  logic                  next_outputEnable_n;
  logic                  next_writeEnable_n;
  logic                  next_ioRead_n;
  logic                  next_ioWrite_n;
  logic [2*NUM_SOCK-1:0] next_chipEnable_n;
  logic                  next_ideCycle;
  logic                  next_xcvr_direction;
  logic [NUM_SOCK-1:0]   next_socket_insert_n;
  logic                  next_hold_indicator_n;
  logic                  sockOk;
  logic                  isRead;

  // Strobe levels as {ioWrite_n, ioRead_n, writeEnable_n, outputEnable_n}.
  function automatic logic [3:0] fscb_strobe_n(input fscb_cmd_t c,
                                               input logic      active);
    logic [3:0] levels;
    levels = {4{STROBE_IDLE}};
    if (active) begin
      unique case (c)
        FSCB_MEM_RD: levels[0] = 1'b0;
        FSCB_MEM_WR: levels[1] = 1'b0;
        FSCB_IO_RD:  levels[2] = 1'b0;
        FSCB_IO_WR:  levels[3] = 1'b0;
      endcase
    end
    return levels;
  endfunction

  // Card address of a cycle: IDE and I/O cycles clear the unused lines.
  function automatic logic [ADDR_W-1:0] fscb_card_addr(
    input logic              ide,
    input logic              io,
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] result;
    result = a;
    if (ide) begin
      result = {{(ADDR_W-IDE_ADDR_W){1'b0}}, a[IDE_ADDR_W-1:0]};
    end else if (io) begin
      result = {{(ADDR_W-IO_ADDR_W){1'b0}}, a[IO_ADDR_W-1:0]};
    end
    return result;
  endfunction

  fscb_reset_sync u_reset_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .syncRst_n (syncRst_n)
  );

  // All state uses the synchronised reset so that release is clean.
  // socket count check
  // Sockets two and three do not exist in mode zero; their enables stay high.
  assign sockOk = fourSocketMode ||
                  (reqSocket <= SOCK_W'(MODE_TWO_SOCK_MAX));
  assign isRead = (cmd == FSCB_MEM_RD) || (cmd == FSCB_IO_RD);

  // Strobes default high so that every phase ends with them released.
  always_comb begin
    next_state                = state;
    next_count                = count;
    next_cmd                  = cmd;
    next_reqReady             = 1'b0;
    next_shared_card_data_out = shared_card_data_out;
    next_shared_card_data_oe  = shared_card_data_oe;
    next_shared_card_addr     = shared_card_addr;
    next_attrSelect_n         = attrSelect_n;
    next_outputEnable_n       = STROBE_IDLE;
    next_writeEnable_n        = STROBE_IDLE;
    next_ioRead_n             = STROBE_IDLE;
    next_ioWrite_n            = STROBE_IDLE;
    next_chipEnable_n         = chipEnable_n;
    next_ideCycle             = ideCycle;
    next_xcvr_direction       = xcvr_direction;
    unique case (state)
      FSCB_IDLE: begin
        next_chipEnable_n = {NUM_SOCK{CE_IDLE}};
        next_shared_card_data_oe = 1'b0;
        next_ideCycle = 1'b0;
        if (reqValid) begin
          next_reqReady = 1'b1;
          next_cmd      = fscb_cmd_t'(reqCmd);
          next_ideCycle = reqIde;
          next_shared_card_addr =
            fscb_card_addr(reqIde, reqCmd[1], reqAddr);
          next_attrSelect_n = !(reqCmd[1] || reqAttr);
          next_xcvr_direction = reqIde ? xcvr_direction : !reqCmd[0];
          // shared data drive
          // Write data is driven from the first cycle so it settles early.
          next_shared_card_data_out = reqWrData;
          next_shared_card_data_oe  = reqCmd[0];
          if (!reqIde && sockOk && socketEnable[reqSocket]) begin
            next_chipEnable_n[2*reqSocket +: 2] =
              fscb_ce_n(reqWide, reqAddr[0]);
          end
          // Each phase counter loads its length and steps down to one.
          next_count = SETUP_CYC;
          next_state = FSCB_SETUP;
        end
      end
      FSCB_SETUP: begin
        next_count = count - 4'h1;
        if (count == 4'h1) begin
          next_count = STROBE_CYC;
          next_state = FSCB_STROBE;
        end
      end
      FSCB_STROBE: begin
        {next_ioWrite_n, next_ioRead_n, next_writeEnable_n,
         next_outputEnable_n} = fscb_strobe_n(cmd, count != 4'h1);
        next_count = count - 4'h1;
        if (count == 4'h1) begin
          next_count = HOLD_CYC;
          next_state = FSCB_HOLD;
        end
      end
      FSCB_HOLD: begin
        // The hold phase keeps address and data steady after the strobe.
        next_count = count - 4'h1;
        if (count == 4'h1) begin
          next_attrSelect_n = 1'b1;
          next_chipEnable_n = {NUM_SOCK{CE_IDLE}};
          next_shared_card_data_oe = 1'b0;
          next_ideCycle = 1'b0;
          next_state = FSCB_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    next_socket_insert_n  = {NUM_SOCK{1'b1}};
    next_hold_indicator_n = 1'b1;
    if (fourSocketMode) begin
      next_socket_insert_n  = ~socketInserted;
      next_hold_indicator_n = !holdRequest;
    end
  end

  always_ff @(posedge clk or negedge syncRst_n) begin
    if (!syncRst_n) begin
      socket_insert_n  <= {NUM_SOCK{1'b1}};
      hold_indicator_n <= 1'b1;
    end else begin
      socket_insert_n  <= next_socket_insert_n;
      hold_indicator_n <= next_hold_indicator_n;
    end
  end

  // Response group: read data is taken on the last strobe cycle.
  always_comb begin
    next_rspValid  = 1'b0;
    next_rspRdData = rspRdData;
    if (state == FSCB_STROBE && count == 4'h1 && isRead) begin
      next_rspRdData = shared_card_data_in;
    end
    if (state == FSCB_HOLD && count == 4'h1) begin
      next_rspValid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge syncRst_n) begin
    if (!syncRst_n) begin
      rspValid  <= 1'b0;
      rspRdData <= 16'h0000;
    end else begin
      rspValid  <= next_rspValid;
      rspRdData <= next_rspRdData;
    end
  end

  always_ff @(posedge clk or negedge syncRst_n) begin
    if (!syncRst_n) begin
      state                <= FSCB_IDLE;
      count                <= 4'h0;
      cmd                  <= FSCB_MEM_RD;
      reqReady             <= 1'b0;
      shared_card_data_out <= 16'h0000;
      shared_card_data_oe  <= 1'b0;
      shared_card_addr     <= 26'h0000000;
      attrSelect_n         <= STROBE_IDLE;
      outputEnable_n       <= STROBE_IDLE;
      writeEnable_n        <= STROBE_IDLE;
      ioRead_n             <= STROBE_IDLE;
      ioWrite_n            <= STROBE_IDLE;
      chipEnable_n         <= {NUM_SOCK{CE_IDLE}};
      ideCycle             <= 1'b0;
      xcvr_direction       <= XCVR_DIR_RESET;
    end else begin
      state                <= next_state;
      count                <= next_count;
      cmd                  <= next_cmd;
      reqReady             <= next_reqReady;
      shared_card_data_out <= next_shared_card_data_out;
      shared_card_data_oe  <= next_shared_card_data_oe;
      shared_card_addr     <= next_shared_card_addr;
      attrSelect_n         <= next_attrSelect_n;
      outputEnable_n       <= next_outputEnable_n;
      writeEnable_n        <= next_writeEnable_n;
      ioRead_n             <= next_ioRead_n;
      ioWrite_n            <= next_ioWrite_n;
      chipEnable_n         <= next_chipEnable_n;
      ideCycle             <= next_ideCycle;
      xcvr_direction       <= next_xcvr_direction;
    end
  end
endmodule // fscb_card_port
`default_nettype wire

// file: logic/fscb_pkg.sv
// Package with constants and types of the four-socket card bus port.
package fscb_pkg;
  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 26;
  localparam int IO_ADDR_W   = 16;
  localparam int IDE_ADDR_W  = 3;
  localparam int NUM_SOCK    = 4;
  localparam int SOCK_W      = 2;
  localparam int MODE_TWO_SOCK_MAX = 1;
  // Strobe timing in nanoseconds and the derived cycle counts at 25 MHz.
  localparam int CLK_NS      = 40;
  localparam int SETUP_NS    = 80;
  localparam int STROBE_NS   = 160;
  localparam int HOLD_NS     = 40;
  localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  // Reset values of the card-side outputs.
  localparam logic XCVR_DIR_RESET = 1'b0;
  localparam logic STROBE_IDLE    = 1'b1;
  localparam logic [1:0] CE_IDLE  = 2'h3;

  typedef enum logic [1:0] {
    FSCB_MEM_RD,
    FSCB_MEM_WR,
    FSCB_IO_RD,
    FSCB_IO_WR
  } fscb_cmd_t;

  typedef enum {
    FSCB_IDLE,
    FSCB_SETUP,
    FSCB_STROBE,
    FSCB_HOLD
  } fscb_state_t;

  // Byte lane enables: bit 0 is the even byte, bit 1 the odd byte.
  function automatic logic [1:0] fscb_ce_n(input logic wide,
                                           input logic a0);
    if (wide) begin
      return 2'h0;
    end
    return a0 ? 2'h1 : 2'h2;
  endfunction
endpackage

// file: logic/fscb_reset_sync.sv
// Reset synchroniser that releases the active low reset through two flops.
`timescale 1ns/1ns
`default_nettype none
module fscb_reset_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic syncRst_n
);
  logic stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1    <= 1'b0;
      syncRst_n <= 1'b0;
    end else begin
      stage1    <= 1'b1;
      syncRst_n <= stage1;
    end
  end
endmodule // fscb_reset_sync
`default_nettype wire

// file: tb/fscb_card_model.sv
// Behavioural model of memory and I/O cards in four sockets.
`timescale 1ns/1ns
`default_nettype none
module fscb_card_model (
  input  wire logic        clk,
  input  wire logic [15:0] wrData,
  input  wire logic [25:0] addr,
  input  wire logic        sel_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        ior_n,
  input  wire logic        iow_n,
  input  wire logic [7:0]  ce_n,
  output var  logic [15:0] rdData
);
  logic [15:0] mem [4][3][8];
  logic [15:0] last;
  logic [1:0]  lane;
  logic [1:0]  k;
  logic        rd;
  logic        wr;
  int          s;
  always_comb begin
    s = -1;
    lane = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (ce_n[2*i+:2] != 2'h3) begin
        s = i;
        lane = ~ce_n[2*i+:2];
      end
    end
    k = sel_n ? 2'h0 : ((!ior_n || !iow_n) ? 2'h2 : 2'h1);
    rd = !oe_n || (!ior_n && !sel_n);
    wr = !we_n || (!iow_n && !sel_n);
  end
  assign rdData = (rd && s >= 0) ? mem[s[1:0]][k][addr[3:1]] : ~last;
  always_ff @(posedge clk) begin
    last <= rdData;
    if (wr && s >= 0 && lane[0]) begin
      mem[s[1:0]][k][addr[3:1]][7:0] <= wrData[7:0];
    end
    if (wr && s >= 0 && lane[1]) begin
      mem[s[1:0]][k][addr[3:1]][15:8] <= wrData[15:8];
    end
  end
endmodule // fscb_card_model
`default_nettype wire

// file: tb/fscb_card_port_bench.sv
// Self-checking testbench of the card bus port.
`timescale 1ns/1ns
`default_nettype none
module fscb_card_port_bench;
  logic clk, rst_n, fourSocketMode, reqValid, reqReady, reqAttr, reqIde;
  logic reqWide, holdRequest, rspValid, shared_card_data_oe, attrSelect_n;
  logic outputEnable_n, writeEnable_n, ioRead_n, ioWrite_n, ideCycle;
  logic xcvr_direction, hold_indicator_n, dirSeen, selSeen;
  logic [1:0]  reqCmd, reqSocket, flagSeen;
  logic [3:0]  socketEnable, socketInserted, socket_insert_n, strSeen;
  logic [7:0]  chipEnable_n, ceSeen;
  logic [15:0] reqWrData, rspRdData, shared_card_data_in;
  logic [15:0] shared_card_data_out, rdSeen;
  logic [25:0] reqAddr, shared_card_addr, addrSeen;
  int          miscompares = 0;
  int          n_compared = 0;
  fscb_card_port u_fscb_card_port (.clk, .rst_n, .fourSocketMode, .reqValid,
    .reqReady, .reqCmd, .reqAttr, .reqIde, .reqWide, .reqSocket, .reqAddr,
    .reqWrData, .socketEnable, .socketInserted, .holdRequest, .rspValid,
    .rspRdData, .shared_card_data_in, .shared_card_data_out,
    .shared_card_data_oe, .shared_card_addr, .attrSelect_n, .outputEnable_n,
    .writeEnable_n, .ioRead_n, .ioWrite_n, .chipEnable_n, .ideCycle,
    .xcvr_direction, .socket_insert_n, .hold_indicator_n);
  fscb_card_model u_fscb_card_model (.clk, .wrData(shared_card_data_out),
    .addr(shared_card_addr), .sel_n(attrSelect_n), .oe_n(outputEnable_n),
    .we_n(writeEnable_n), .ior_n(ioRead_n), .iow_n(ioWrite_n),
    .ce_n(chipEnable_n), .rdData(shared_card_data_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input logic [1:0] c, input logic a, ide, w,
                     input logic [1:0] s, input logic [25:0] ad,
                     input logic [15:0] wd);
    int n;
    {reqCmd, reqAttr, reqIde, reqWide} = {c, a, ide, w};
    {reqSocket, reqAddr, reqWrData} = {s, ad, wd};
    reqValid = 1'b1;
    ceSeen = 8'hff;
    strSeen = 4'h0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (reqReady === 1'b1) begin
        reqValid = 1'b0;
        {dirSeen, selSeen, addrSeen, flagSeen} = {xcvr_direction,
          attrSelect_n, shared_card_addr, shared_card_data_oe, ideCycle};
      end
      ceSeen &= chipEnable_n;
      strSeen |= ~{ioWrite_n, ioRead_n, writeEnable_n, outputEnable_n};
    end while (rspValid !== 1'b1 && n < 20);
    rdSeen = rspRdData;
    chk(n < 20, 1'b1);
  endtask
  task automatic acc(input logic [1:0] c, input logic a, w,
                     input logic [1:0] s, input logic [25:0] ad,
                     input logic [15:0] wd, input logic [7:0] ce);
    cyc(c, a, 1'b0, w, s, ad, wd);
    chk(ceSeen, ce);
    chk(strSeen, 4'h1 << c);
    chk(dirSeen, !c[0]);
    chk(selSeen, !(a || c[1]));
    chk(addrSeen, ad);
    chk(flagSeen, {c[0], 1'b0});
  endtask
  task automatic t_common();
    for (int k = 0; k < 8; k++) begin
      acc({1'b0, ~k[2]}, 1'b0, 1'b1, k[1:0], {k[1:0], 20'h5a5a5, 4'h6},
          {12'ha5c, 2'h0, k[1:0]}, ~(8'h3 << 2 * k[1:0]));
      if (k > 3) chk(rdSeen, {12'ha5c, 2'h0, k[1:0]});
    end
  endtask
  task automatic t_space();
    int         j;
    logic [1:0] c;
    for (int k = 0; k < 6; k++) begin
      j = k % 3;
      c = (j == 2) ? 2'h3 : 2'h1;
      c[0] = (k < 3);
      acc(c, j == 1, 1'b1, 2'h1, 26'h6, {14'h0, j[1:0]} ^ 16'h7e00, 8'hf3);
      if (k > 2) chk(rdSeen, {14'h0, j[1:0]} ^ 16'h7e00);
    end
  endtask
  task automatic t_ide();
    acc(2'h1, 1'b0, 1'b0, 2'h3, 26'h1, 16'h0, 8'h7f);
    acc(2'h0, 1'b0, 1'b0, 2'h3, 26'h0, 16'h0, 8'hbf);
    cyc(2'h2, 1'b0, 1'b1, 1'b1, 2'h0, 26'h3fffffd, 16'h0);
    chk(addrSeen[2:0], 3'h5);
    chk(ceSeen, 8'hff);
    chk(dirSeen, 1'b1);
    chk(flagSeen, 2'h1);
  endtask
  task automatic t_mode();
    socketEnable = 4'hd;
    acc(2'h0, 1'b0, 1'b1, 2'h1, 26'h6, 16'h0, 8'hff);
    {socketEnable, fourSocketMode, holdRequest, socketInserted} = 10'h3da;
    repeat (3) @(negedge clk);
    chk({hold_indicator_n, socket_insert_n}, 5'h1f);
    acc(2'h0, 1'b0, 1'b1, 2'h2, 26'h6, 16'h0, 8'hff);
    acc(2'h0, 1'b0, 1'b1, 2'h1, 26'h6, 16'h0, 8'hf3);
    fourSocketMode = 1'b1;
    repeat (3) @(negedge clk);
    chk({hold_indicator_n, socket_insert_n}, 5'h05);
  endtask
  initial begin
    {rst_n, reqValid, reqCmd, reqAttr, reqIde, reqWide} = '0;
    {reqSocket, reqAddr, reqWrData, holdRequest, socketInserted} = '0;
    {fourSocketMode, socketEnable} = 5'h1f;
    repeat (3) @(negedge clk);
    chk({xcvr_direction, chipEnable_n}, 9'h0ff);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_common();
    t_space();
    t_ide();
    t_mode();
    stop_test();
  end
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
endmodule // fscb_card_port_bench
`default_nettype wire

// file: tb/fscb_card_port_chk.sv
// Assertions on the card-side ports of the card bus port.
`timescale 1ns/1ns
`default_nettype none
module fscb_card_port_chk
  import fscb_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  fourSocketMode,
  input wire logic                  reqReady,
  input wire logic                  rspValid,
  input wire logic                  attrSelect_n,
  input wire logic                  outputEnable_n,
  input wire logic                  writeEnable_n,
  input wire logic                  ioRead_n,
  input wire logic                  ioWrite_n,
  input wire logic [2*NUM_SOCK-1:0] chipEnable_n,
  input wire logic                  ideCycle,
  input wire logic                  xcvr_direction,
  input wire logic [NUM_SOCK-1:0]   socket_insert_n,
  input wire logic                  hold_indicator_n
);
  logic [NUM_SOCK-1:0] act;
  always_comb begin
    for (int i = 0; i < NUM_SOCK; i++) begin
      act[i] = ~&chipEnable_n[2*i+:2];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse3(sig);
    (!sig)[*3] ##1 sig;
  endsequence
  a_iord_width: assert property ($fell(ioRead_n) |-> s_pulse3(ioRead_n))
    else $error("I/O read strobe width wrong");
  a_oe_width: assert property ($fell(outputEnable_n) |-> s_pulse3(outputEnable_n))
    else $error("Output enable width wrong");
  a_done_fixed: assert property (reqReady |-> ##[5:7] rspValid)
    else $error("Cycle did not complete in time");
  a_iord_sel: assert property (!ioRead_n |-> !attrSelect_n)
    else $error("I/O read without select");
  a_iowr_sel: assert property (!ioWrite_n |-> !attrSelect_n)
    else $error("I/O write without select");
  a_dir_read: assert property ((!outputEnable_n || !ioRead_n) && !ideCycle |-> xcvr_direction)
    else $error("Direction low during read");
  a_dir_write: assert property ((!writeEnable_n || !ioWrite_n) && !ideCycle |-> !xcvr_direction)
    else $error("Direction high during write");
  a_one_socket: assert property ($onehot0(act))
    else $error("Several sockets enabled");
  a_mode0_quiet: assert property (!fourSocketMode && !$past(fourSocketMode) |-> hold_indicator_n && &socket_insert_n)
    else $error("Indicators active in mode zero");
  a_mode0_no_ce: assert property (!fourSocketMode |-> &chipEnable_n[2*NUM_SOCK-1:4])
    else $error("Upper socket enabled in mode zero");
endmodule // fscb_card_port_chk
bind fscb_card_port fscb_card_port_chk u_fscb_card_port_chk (.clk, .rst_n,
  .fourSocketMode, .reqReady, .rspValid, .attrSelect_n, .outputEnable_n,
  .writeEnable_n, .ioRead_n, .ioWrite_n, .chipEnable_n, .ideCycle,
  .xcvr_direction, .socket_insert_n, .hold_indicator_n);
`default_nettype wire
